// file: hdl/gptf_cfg.svh
// Register offsets, bit positions and reset values for the pin control block
`ifndef GPTF_CFG_SVH
`define GPTF_CFG_SVH

`define GPTF_PIN_CTRL_ADDR   12'h000
`define GPTF_BIT_PIN3_IN     12
`define GPTF_BIT_PIN3_DIR    13
`define GPTF_BIT_PIN3_OUT    14
`define GPTF_BIT_RSVD        15
`define GPTF_BIT_PIN4_IN     16
`define GPTF_BIT_PIN4_DIR    17
`define GPTF_BIT_PIN4_OUT    18
`define GPTF_CTRL_RESET      1'b0
`define GPTF_RDATA_ZERO      32'h0000_0000
`define GPTF_SYNC_RESET      3'h0
`define GPTF_LVL_RESET       1'b0

`endif

// file: hdl/gptf_pkg.sv
// Types shared by the pin control block
package gptf_pkg;
	// Software-owned state of one pin
	typedef struct packed {
		logic dir;
		logic out;
	} gptf_pin_s;

	// Pin-side signals of one pin
	typedef struct packed {
		logic o;
		logic oe;
	} gptf_drive_s;
endpackage

// file: hdl/gptf_pin_ctrl.sv
// APB-reached control of general pins 3 and 4
//
// What this block does
// - Pin 3 direction bit zero makes it input, one makes it output.
// - Pin 3 output value, bit 14, drives the pin while configured output.
// - Bit 15 is reserved; it stores what software writes and reads back.
// - Bit 16 reads the sampled level of pin 4; writes ignored.
// - Pin 4 direction, bit 17, zero means input, one means output.
// - Pin 4 output value drives the pin while configured output.
// - Pin 3 direction sits at bit 13, read and write.
// - Pin 4 output value sits at bit 18, read and write.
//
// The implementer's own choices: the APB register port and the address map.
`timescale 1ns/1ps
`include "gptf_cfg.svh"

module gptf_pin_ctrl
	import gptf_pkg::*;
(
	input  wire logic        ref_clk,
	input  wire logic        rst_n,
	input  wire logic        clk_en,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [11:0] paddr,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	input  wire logic        pin3_level,
	output logic             pin3_value,
	output logic             pin3_oe,
	input  wire logic        pin4_level,
	output logic             pin4_value,
	output logic             pin4_oe
);

	// Software-owned control bits
	gptf_pin_s   pin3;
	gptf_pin_s   pin4;
	logic        rsvd;
	gptf_pin_s   next_pin3;
	gptf_pin_s   next_pin4;
	logic        next_rsvd;

	// Pin synchronisers and filtered levels
	logic [2:0]  sync3;
	logic [2:0]  sync4;
	logic        lvl3;
	logic        lvl4;
	logic [2:0]  next_sync3;
	logic [2:0]  next_sync4;
	logic        next_lvl3;
	logic        next_lvl4;

	// Bus decode and read word
	logic        hit;
	logic        wr_en;
	logic        rd_en;
	logic [31:0] next_prdata;

	// Registered pin drive
	gptf_drive_s drv3;
	gptf_drive_s drv4;
	gptf_drive_s next_drv3;
	gptf_drive_s next_drv4;

	// Bus decode: one word mapped, no wait states
	assign hit     = (paddr == `GPTF_PIN_CTRL_ADDR);
	assign wr_en   = psel && penable && pwrite && hit && clk_en;
	// Read word captured in setup, so it already stands in the access phase
	assign rd_en   = psel && !penable && !pwrite && clk_en;
	assign pready  = 1'b1;
	// Unmapped offsets flag an error rather than alias onto the one word
	assign pslverr = psel && penable && !hit;

	// Next control bits; writes to the level bits are simply dropped
	always_comb begin
		next_pin3 = pin3;
		next_pin4 = pin4;
		next_rsvd = rsvd;
		if (wr_en) begin
			next_pin3.dir = pwdata[`GPTF_BIT_PIN3_DIR];
			next_pin3.out = pwdata[`GPTF_BIT_PIN3_OUT];
			next_rsvd     = pwdata[`GPTF_BIT_RSVD];
			next_pin4.dir = pwdata[`GPTF_BIT_PIN4_DIR];
			next_pin4.out = pwdata[`GPTF_BIT_PIN4_OUT];
		end
	end

	// Control bits; reset leaves both pins as inputs
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			pin3 <= '{dir: `GPTF_CTRL_RESET, out: `GPTF_CTRL_RESET};
			pin4 <= '{dir: `GPTF_CTRL_RESET, out: `GPTF_CTRL_RESET};
			rsvd <= `GPTF_CTRL_RESET;
		end else if (clk_en) begin
			pin3 <= next_pin3;
			pin4 <= next_pin4;
			rsvd <= next_rsvd;
		end
	end

	// Shift the raw pins in; a level counts once stages two and three agree
	always_comb begin
		next_sync3 = {sync3[1:0], pin3_level};
		next_sync4 = {sync4[1:0], pin4_level};
		// Disagreeing stages keep the old level, so one-cycle glitches never show
		next_lvl3  = (sync3[1] == sync3[2]) ? sync3[2] : lvl3;
		next_lvl4  = (sync4[1] == sync4[2]) ? sync4[2] : lvl4;
	end

	// Synchroniser flops; only stage two reads stage one
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			sync3 <= `GPTF_SYNC_RESET;
			sync4 <= `GPTF_SYNC_RESET;
			lvl3  <= `GPTF_LVL_RESET;
			lvl4  <= `GPTF_LVL_RESET;
		end else if (clk_en) begin
			sync3 <= next_sync3;
			sync4 <= next_sync4;
			lvl3  <= next_lvl3;
			lvl4  <= next_lvl4;
		end
	end

	// Read word from stored bits and filtered levels; unused bits read zero
	always_comb begin
		next_prdata = prdata;
		if (rd_en) begin
			next_prdata = `GPTF_RDATA_ZERO;
			if (hit) begin
				next_prdata[`GPTF_BIT_PIN3_IN]  = lvl3;
				next_prdata[`GPTF_BIT_PIN3_DIR] = pin3.dir;
				next_prdata[`GPTF_BIT_PIN3_OUT] = pin3.out;
				next_prdata[`GPTF_BIT_RSVD]     = rsvd;
				next_prdata[`GPTF_BIT_PIN4_IN]  = lvl4;
				next_prdata[`GPTF_BIT_PIN4_DIR] = pin4.dir;
				next_prdata[`GPTF_BIT_PIN4_OUT] = pin4.out;
			end
		end
	end

	// Read data flop; the word stands until the next read setup
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			prdata <= `GPTF_RDATA_ZERO;
		end else if (clk_en) begin
			prdata <= next_prdata;
		end
	end

	// Drive follows the next control bits, so pins move on the write edge itself
	always_comb begin
		next_drv3.oe = next_pin3.dir;
		// A released pin also has its value held low, so no stale level leaks out
		next_drv3.o  = next_pin3.dir & next_pin3.out;
		next_drv4.oe = next_pin4.dir;
		next_drv4.o  = next_pin4.dir & next_pin4.out;
	end

	// Drive flops keep the pin outputs free of decode glitches
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			drv3 <= '{o: `GPTF_CTRL_RESET, oe: `GPTF_CTRL_RESET};
			drv4 <= '{o: `GPTF_CTRL_RESET, oe: `GPTF_CTRL_RESET};
		end else if (clk_en) begin
			drv3 <= next_drv3;
			drv4 <= next_drv4;
		end
	end

	// Pin outputs straight from the drive flops
	assign pin3_value = drv3.o;
	assign pin3_oe    = drv3.oe;
	assign pin4_value = drv4.o;
	assign pin4_oe    = drv4.oe;

	// Pin 3 drive and control bits
	a_pin3_dir_oe: assert property (@(posedge ref_clk) disable iff (!rst_n)
		pin3_oe == pin3.dir)
		else $error("pin3 enable differs from direction");
	a_pin3_quiet: assert property (@(posedge ref_clk) disable iff (!rst_n)
		!pin3_oe |-> !pin3_value)
		else $error("pin3 value driven while input");
	a_pin3_drive: assert property (@(posedge ref_clk) disable iff (!rst_n)
		pin3_oe |-> pin3_value == pin3.out)
		else $error("pin3 not driving value");
	a_pin3_out_rw: assert property (@(posedge ref_clk) disable iff (!rst_n)
		wr_en |=> pin3.out == $past(pwdata[`GPTF_BIT_PIN3_OUT]))
		else $error("pin3 value write lost");
	a_pin3_dir_rw: assert property (@(posedge ref_clk) disable iff (!rst_n)
		wr_en |=> pin3.dir == $past(pwdata[`GPTF_BIT_PIN3_DIR]))
		else $error("pin3 direction write lost");
	a_pin3_dir_read: assert property (@(posedge ref_clk) disable iff (!rst_n)
		(rd_en && hit) |=> prdata[`GPTF_BIT_PIN3_DIR] == $past(pin3.dir))
		else $error("pin3 direction not read");

	// Reserved storage bit
	a_rsvd_keep: assert property (@(posedge ref_clk) disable iff (!rst_n)
		wr_en |=> rsvd == $past(pwdata[`GPTF_BIT_RSVD]))
		else $error("reserved bit not stored");
	a_rsvd_read: assert property (@(posedge ref_clk) disable iff (!rst_n)
		(rd_en && hit) |=> prdata[`GPTF_BIT_RSVD] == $past(rsvd))
		else $error("reserved bit not read back");

	// Pin 4 level, drive and control bits
	a_pin4_read: assert property (@(posedge ref_clk) disable iff (!rst_n)
		(rd_en && hit) |=> prdata[`GPTF_BIT_PIN4_IN] == $past(lvl4))
		else $error("pin4 level not read");
	a_pin4_level: assert property (@(posedge ref_clk) disable iff (!rst_n)
		clk_en && sync4[1] == sync4[2] |=> lvl4 == $past(sync4[2]))
		else $error("pin4 level not tracked");
	a_pin4_dir_oe: assert property (@(posedge ref_clk) disable iff (!rst_n)
		wr_en |=> pin4_oe == $past(pwdata[`GPTF_BIT_PIN4_DIR]))
		else $error("pin4 direction write lost");
	a_pin4_oe_match: assert property (@(posedge ref_clk) disable iff (!rst_n)
		pin4_oe == pin4.dir)
		else $error("pin4 enable differs from direction");
	a_pin4_drive: assert property (@(posedge ref_clk) disable iff (!rst_n)
		!pin4_oe || pin4_value == pin4.out)
		else $error("pin4 not driving value");
	a_pin4_out_rw: assert property (@(posedge ref_clk) disable iff (!rst_n)
		wr_en |=> pin4.out == $past(pwdata[`GPTF_BIT_PIN4_OUT]))
		else $error("pin4 value write lost");
	a_pin4_out_read: assert property (@(posedge ref_clk) disable iff (!rst_n)
		(rd_en && hit) |=> prdata[`GPTF_BIT_PIN4_OUT] == $past(pin4.out))
		else $error("pin4 value not read");

	// Reset, clock enable and bus answer
	a_reset_inputs: assert property (@(posedge ref_clk)
		$rose(rst_n) |-> !pin3_oe && !pin4_oe)
		else $error("pins not inputs after reset");
	a_reset_values: assert property (@(posedge ref_clk)
		$rose(rst_n) |-> !(|{pin3, pin4, rsvd}) && prdata == `GPTF_RDATA_ZERO)
		else $error("control bits not cleared by reset");
	a_freeze_state: assert property (@(posedge ref_clk) disable iff (!rst_n)
		!clk_en |=> $stable({pin3, pin4, rsvd, drv3, drv4, lvl3, lvl4, prdata}))
		else $error("state moved while clock enable low");
	a_slverr_map: assert property (@(posedge ref_clk) disable iff (!rst_n)
		(psel && penable) |-> pslverr == !hit)
		else $error("error response does not match decode");
	a_ready_high: assert property (@(posedge ref_clk) disable iff (!rst_n)
		pready)
		else $error("ready dropped");

endmodule

// file: verification/gptf_board.sv
// Board model: resolves each pin from device drive and board level
`timescale 1ns/1ps
module gptf_board (
	input  wire logic pin3_value,
	input  wire logic pin3_oe,
	input  wire logic pin4_value,
	input  wire logic pin4_oe,
	input  wire logic ext3,
	input  wire logic ext4,
	output logic      pin3_level,
	output logic      pin4_level
);
	// Driven pin follows the device, released pin follows the board
	assign pin3_level = pin3_oe ? pin3_value : ext3;
	assign pin4_level = pin4_oe ? pin4_value : ext4;
endmodule

// file: verification/test_general_pin_three_four_control.sv
// Bench for the pin control block
`timescale 1ns/1ps
module test_general_pin_three_four_control;
	logic        ref_clk = 0;
	logic        rst_n = 0;
	logic        psel = 0;
	logic        penable = 0;
	logic        pwrite = 0;
	logic [11:0] paddr = '0;
	logic [31:0] pwdata = '0;
	logic [31:0] prdata, rd;
	logic        pready, pslverr, err, pin3_level, pin3_value, pin3_oe;
	logic        pin4_level, pin4_value, pin4_oe;
	logic        clk_en = 1;
	logic        ext3 = 0;
	logic        ext4 = 0;
	int          fail_count = 0;
	int          compares = 0;
	wire  [31:0] pins = {28'h0, pin3_oe, pin3_value, pin4_oe, pin4_value};

	gptf_pin_ctrl uut (.ref_clk, .rst_n, .clk_en, .psel, .penable, .pwrite, .paddr,
		.pwdata, .prdata, .pready, .pslverr, .pin3_level, .pin3_value, .pin3_oe,
		.pin4_level, .pin4_value, .pin4_oe);
	gptf_board board (.pin3_value, .pin3_oe, .pin4_value, .pin4_oe, .ext3, .ext4,
		.pin3_level, .pin4_level);

	always #10 ref_clk = ~ref_clk;

	// Gap first, so the pin synchroniser settles before any read
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		repeat (4) @(posedge ref_clk);
		psel <= 1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge ref_clk);
		penable <= 1;
		do @(posedge ref_clk); while (pready !== 1'b1);
		rd = prdata;
		err = pslverr;
		psel <= 0;
		penable <= 0;
		#1;
	endtask

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		compares++;
		if (got !== exp) begin
			fail_count++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic end_sim();
		$display("compares %0d fail_count %0d", compares, fail_count);
		if (fail_count == 0 && compares > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask

	// Watchdog far beyond the hundred or so cycles needed
	initial begin
		#100000;
		fail_count++;
		end_sim();
	end

	initial begin
		repeat (3) @(posedge ref_clk);
		rst_n <= 1;
		apb(0, 12'h000, 32'h0);
		chk(rd, 32'h0);
		chk(pins, 32'h0);
		apb(1, 12'h000, 32'h0000_6000);
		chk(pins, 32'hc);
		chk({31'h0, err}, 32'h0);
		apb(0, 12'h000, 32'h0);
		chk(rd, 32'h0000_7000);
		apb(1, 12'h000, 32'h0001_8000);
		chk(pins, 32'h0);
		apb(0, 12'h000, 32'h0);
		chk(rd, 32'h0000_8000);
		@(posedge ref_clk);
		ext4 <= 1;
		apb(0, 12'h000, 32'h0);
		chk(rd, 32'h0001_8000);
		@(posedge ref_clk);
		ext4 <= 0;
		apb(1, 12'h000, 32'h0004_0000);
		chk(pins, 32'h0);
		apb(1, 12'h000, 32'h0006_0000);
		chk(pins, 32'h3);
		apb(0, 12'h000, 32'h0);
		chk(rd, 32'h0007_0000);
		apb(1, 12'h004, 32'hffff_ffff);
		chk({31'h0, err}, 32'h1);
		apb(0, 12'h004, 32'h0);
		chk(rd, 32'h0);
		apb(0, 12'h000, 32'h0);
		chk(rd, 32'h0007_0000);
		// A write while frozen must leave every bit alone
		@(posedge ref_clk);
		clk_en <= 0;
		apb(1, 12'h000, 32'h0000_0000);
		chk(pins, 32'h3);
		@(posedge ref_clk);
		clk_en <= 1;
		apb(0, 12'h000, 32'h0);
		chk(rd, 32'h0007_0000);
		@(posedge ref_clk);
		rst_n <= 0;
		#1;
		chk(pins, 32'h0);
		@(posedge ref_clk);
		rst_n <= 1;
		apb(0, 12'h000, 32'h0);
		chk(rd, 32'h0);
		end_sim();
	end
endmodule
